// File: cstw_defs.vh
// Constants for the cyclic sense and wake timer block
`ifndef CSTW_DEFS_VH
`define CSTW_DEFS_VH
// Register address and width
`define CSTW_ADDR_TIMER_CTRL 7'h06
`define CSTW_REG_W 16
`define CSTW_RST_VAL 16'h0000
// Field positions
`define CSTW_T2_ON_HI 15
`define CSTW_T2_ON_LO 13
`define CSTW_T2_PER_HI 11
`define CSTW_T2_PER_LO 9
`define CSTW_WAKE_HI 8
`define CSTW_WAKE_LO 7
`define CSTW_T1_ON_HI 6
`define CSTW_T1_ON_LO 4
`define CSTW_T1_PER_HI 2
`define CSTW_T1_PER_LO 0
// Writable bit mask, reserved bits 12 and 3 clear
`define CSTW_WR_MASK 16'hEFF7
// On-time codes
`define CSTW_ON_OFF_LOW 3'h0
`define CSTW_ON_100US 3'h1
`define CSTW_ON_300US 3'h2
`define CSTW_ON_1MS 3'h3
`define CSTW_ON_10MS 3'h4
`define CSTW_ON_20MS 3'h5
// Wake select codes
`define CSTW_WAKE_T1 2'h1
`define CSTW_WAKE_T2 2'h2
// Timing: 20 MHz clock, 100 us tick base
`define CSTW_CLK_KHZ 20000
`define CSTW_TICK_US 100
`define CSTW_TICK_CYC ((`CSTW_CLK_KHZ * `CSTW_TICK_US) / 1000)
`define CSTW_PRE_W 12
// Times in 100 us ticks
`define CSTW_TK_W 15
`define CSTW_TK_100US 15'h0001
`define CSTW_TK_300US 15'h0003
`define CSTW_TK_1MS 15'h000A
`define CSTW_TK_10MS 15'h0064
`define CSTW_TK_20MS 15'h00C8
`define CSTW_TK_50MS 15'h01F4
`define CSTW_TK_100MS 15'h03E8
`define CSTW_TK_200MS 15'h07D0
`define CSTW_TK_500MS 15'h1388
`define CSTW_TK_1S 15'h2710
`define CSTW_TK_2S 15'h4E20
`endif

// File: cstw_timers.v
// Cyclic sense and cyclic wake timer pair with control register
// ==========================================================
`include "cstw_defs.vh"
`default_nettype none

module cstw_timers (
  input wire i_sys_clk, // 20 MHz internal oscillator
  input wire i_rst_b, // Power-on or soft reset, async low
  input wire i_restart, // Restart entry pulse, same clock
  input wire i_hs_clear_t1, // Switch on first timer cleared in restart
  input wire i_hs_clear_t2, // Switch on second timer cleared in restart
  input wire i_wr_en, // Register write strobe
  input wire i_rd_en, // Register read strobe
  input wire [6:0] i_addr, // Register address
  input wire [15:0] i_wr_data, // Write data
  output reg [15:0] o_rd_data, // Read data
  output reg o_first_timer_out, // First timer switch drive
  output reg o_second_timer_out, // Second timer switch drive
  output reg o_first_on_end, // Pulse at end of first on-time
  output reg o_second_on_end, // Pulse at end of second on-time
  output reg o_cyclic_wake // Wake event pulse
);

  // ==========================================================
  // Control register
  reg [15:0] cyclic_timer_control; // Holds both timers' settings
  wire hit; // Address match
  wire [2:0] second_timer_on_time;
  wire [2:0] second_timer_period;
  wire [1:0] cyclic_wake_select;
  wire [2:0] first_timer_on_time;
  wire [2:0] first_timer_period;

  assign hit = (i_addr == `CSTW_ADDR_TIMER_CTRL);
  assign second_timer_on_time = cyclic_timer_control[`CSTW_T2_ON_HI:`CSTW_T2_ON_LO];
  assign second_timer_period = cyclic_timer_control[`CSTW_T2_PER_HI:`CSTW_T2_PER_LO];
  assign cyclic_wake_select = cyclic_timer_control[`CSTW_WAKE_HI:`CSTW_WAKE_LO];
  assign first_timer_on_time = cyclic_timer_control[`CSTW_T1_ON_HI:`CSTW_T1_ON_LO];
  assign first_timer_period = cyclic_timer_control[`CSTW_T1_PER_HI:`CSTW_T1_PER_LO];

  // Write, restart and hardware clears; restart clear wins over write
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cyclic_timer_control <= `CSTW_RST_VAL;
    end else if (i_restart) begin
      cyclic_timer_control <= `CSTW_RST_VAL;
    end else begin
      if (i_wr_en && hit) begin
        // Reserved bits are never stored
        cyclic_timer_control <= i_wr_data & `CSTW_WR_MASK;
      end
      // Only a restart-time switch clear wipes a timer; other faults keep it
      if (i_hs_clear_t1 && (first_timer_on_time != `CSTW_ON_OFF_LOW)) begin
        cyclic_timer_control[`CSTW_T1_ON_HI:`CSTW_T1_PER_LO] <= 7'h00;
      end
      if (i_hs_clear_t2 && (second_timer_on_time != `CSTW_ON_OFF_LOW)) begin
        cyclic_timer_control[`CSTW_T2_ON_HI:`CSTW_T2_PER_LO] <= 7'h00;
      end
    end
  end

  // Registered read data, reflecting hardware clears
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd_en) begin
      o_rd_data <= hit ? (cyclic_timer_control & `CSTW_WR_MASK) : 16'h0000;
    end
  end

  // ==========================================================
  // 100 us tick prescaler from the oscillator
  reg [`CSTW_PRE_W-1:0] pre_cnt; // Cycle counter
  reg tick; // One-cycle 100 us enable

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt <= {`CSTW_PRE_W{1'b0}};
      tick <= 1'b0;
    end else if (pre_cnt == `CSTW_TICK_CYC - 1) begin
      pre_cnt <= {`CSTW_PRE_W{1'b0}};
      tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  // ==========================================================
  // Code to tick count lookups
  function [`CSTW_TK_W-1:0] on_ticks;
    input [2:0] code;
    begin
      case (code)
        `CSTW_ON_100US: on_ticks = `CSTW_TK_100US;
        `CSTW_ON_300US: on_ticks = `CSTW_TK_300US;
        `CSTW_ON_1MS: on_ticks = `CSTW_TK_1MS;
        `CSTW_ON_10MS: on_ticks = `CSTW_TK_10MS;
        `CSTW_ON_20MS: on_ticks = `CSTW_TK_20MS;
        default: on_ticks = {`CSTW_TK_W{1'b0}};
      endcase
    end
  endfunction

  function [`CSTW_TK_W-1:0] per_ticks;
    input [2:0] code;
    begin
      case (code)
        3'h0: per_ticks = `CSTW_TK_10MS;
        3'h1: per_ticks = `CSTW_TK_20MS;
        3'h2: per_ticks = `CSTW_TK_50MS;
        3'h3: per_ticks = `CSTW_TK_100MS;
        3'h4: per_ticks = `CSTW_TK_200MS;
        3'h5: per_ticks = `CSTW_TK_500MS;
        3'h6: per_ticks = `CSTW_TK_1S;
        default: per_ticks = `CSTW_TK_2S;
      endcase
    end
  endfunction

  // Running means a timed on-time code; 000 and 11x hold the timer stopped
  function is_run;
    input [2:0] code;
    begin
      is_run = (code >= `CSTW_ON_100US) && (code <= `CSTW_ON_20MS);
    end
  endfunction

  // ==========================================================
  // Period counters; each starts itself when a timed on-time appears
  reg [`CSTW_TK_W-1:0] cnt1; // First timer phase
  reg [`CSTW_TK_W-1:0] cnt2; // Second timer phase
  wire run1;
  wire run2;
  wire exp1; // Period expiry, first timer
  wire exp2;
  wire onend1; // On-time end, first timer
  wire onend2;

  assign run1 = is_run(first_timer_on_time);
  assign run2 = is_run(second_timer_on_time);
  assign exp1 = run1 && tick && (cnt1 == per_ticks(first_timer_period) - 1'b1);
  assign exp2 = run2 && tick && (cnt2 == per_ticks(second_timer_period) - 1'b1);
  assign onend1 = run1 && tick && (cnt1 == on_ticks(first_timer_on_time) - 1'b1);
  assign onend2 = run2 && tick && (cnt2 == on_ticks(second_timer_on_time) - 1'b1);

  // Counters: stopped ones sit at zero so a new start begins a fresh period
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt1 <= {`CSTW_TK_W{1'b0}};
      cnt2 <= {`CSTW_TK_W{1'b0}};
    end else begin
      if (!run1 || exp1) begin
        cnt1 <= {`CSTW_TK_W{1'b0}};
      end else if (tick) begin
        cnt1 <= cnt1 + 1'b1;
      end
      if (!run2 || exp2) begin
        cnt2 <= {`CSTW_TK_W{1'b0}};
      end else if (tick) begin
        cnt2 <= cnt2 + 1'b1;
      end
    end
  end

  // ==========================================================
  // Output drive, on-time end strobes and wake events
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_first_timer_out <= 1'b0;
      o_second_timer_out <= 1'b0;
      o_first_on_end <= 1'b0;
      o_second_on_end <= 1'b0;
      o_cyclic_wake <= 1'b0;
    end else begin
      // High during on-time; 000 low, 110/111 permanently high
      if (run1) begin
        o_first_timer_out <= (cnt1 < on_ticks(first_timer_on_time)) && !onend1;
      end else begin
        o_first_timer_out <= first_timer_on_time[2] & first_timer_on_time[1];
      end
      if (run2) begin
        o_second_timer_out <= (cnt2 < on_ticks(second_timer_on_time)) && !onend2;
      end else begin
        o_second_timer_out <= second_timer_on_time[2] & second_timer_on_time[1];
      end
      // Filter elsewhere samples on these strobes
      o_first_on_end <= onend1;
      o_second_on_end <= onend2;
      // Wake needs the selected timer's timed on-time code, so its sense output runs too
      case (cyclic_wake_select)
        `CSTW_WAKE_T1: o_cyclic_wake <= exp1;
        `CSTW_WAKE_T2: o_cyclic_wake <= exp2;
        default: o_cyclic_wake <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: cstw_timers_chk.sv
// Port checker for the cyclic sense and wake timer block
`default_nettype none
module cstw_timers_chk (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_restart,
  input wire i_hs_clear_t1,
  input wire i_hs_clear_t2,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [6:0] i_addr,
  input wire [15:0] i_wr_data,
  input wire [15:0] o_rd_data,
  input wire o_first_timer_out,
  input wire o_second_timer_out,
  input wire o_first_on_end,
  input wire o_second_on_end,
  input wire o_cyclic_wake
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // No clearing source active, so a write lands intact
  wire q = !i_restart && !i_hs_clear_t1 && !i_hs_clear_t2;
  wire rd6 = i_rd_en && i_addr == 7'h06;
  // ==========================================
  // Register
  a_reserved_read_zero: assert property (
    o_rd_data[12] == 1'b0 && o_rd_data[3] == 1'b0) else $error("reserved bit read set");
  a_write_reads_back: assert property (
    (i_wr_en && i_addr == 7'h06 && q) ##1 (rd6 && q && !i_wr_en)
    |=> o_rd_data == ($past(i_wr_data, 2) & 16'hEFF7)) else $error("readback mismatch");
  a_restart_clears_all: assert property (
    i_restart ##1 (rd6 && !i_wr_en) |=> o_rd_data == 16'h0000) else $error("restart kept bits");
  a_hs1_clears_on: assert property (
    (i_hs_clear_t1 && !i_wr_en) ##1 (rd6 && !i_wr_en) |=> o_rd_data[6:4] == 3'h0)
    else $error("first on-time kept");
  a_hs2_clears_on: assert property (
    (i_hs_clear_t2 && !i_wr_en) ##1 (rd6 && !i_wr_en) |=> o_rd_data[15:13] == 3'h0)
    else $error("second on-time kept");
  // ==========================================
  // Timer outputs
  a_first_end_falls: assert property (
    o_first_on_end |-> $past(o_first_timer_out) && !o_first_timer_out) else $error("end 1");
  a_second_end_falls: assert property (
    o_second_on_end |-> $past(o_second_timer_out) && !o_second_timer_out) else $error("end 2");
  a_end_single_pulse: assert property (
    o_first_on_end || o_second_on_end |=> !o_first_on_end && !o_second_on_end)
    else $error("on-end pulse too long");
  a_wake_single_pulse: assert property (
    o_cyclic_wake |=> !o_cyclic_wake [*8]) else $error("wake pulse too long");
  c_first_end: cover property (o_first_on_end);
  c_restart_read: cover property (i_restart ##1 rd6);
  c_wake: cover property (o_cyclic_wake);
endmodule
bind cstw_timers cstw_timers_chk cstw_timers_chk_u (.i_sys_clk(i_sys_clk),
  .i_rst_b(i_rst_b), .i_restart(i_restart), .i_hs_clear_t1(i_hs_clear_t1),
  .i_hs_clear_t2(i_hs_clear_t2), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .o_first_timer_out(o_first_timer_out),
  .o_second_timer_out(o_second_timer_out), .o_first_on_end(o_first_on_end),
  .o_second_on_end(o_second_on_end), .o_cyclic_wake(o_cyclic_wake));
`default_nettype wire

// File: cstw_timers_test.sv
// Self-checking bench for the cyclic sense and wake timer block
`default_nettype none
module cstw_timers_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 0, i_rst_b = 0, i_restart = 0, i_hs_clear_t1 = 0, i_hs_clear_t2 = 0;
  logic i_wr_en = 0, i_rd_en = 0, rd_pend = 0;
  logic [6:0] i_addr = 7'h00;
  logic [15:0] i_wr_data = 16'h0000, rnd;
  logic [15:0] exp_q[$]; // Expected read words, oldest first
  logic [2:0] oc[3] = '{3'h0, 3'h6, 3'h7};
  wire [15:0] o_rd_data;
  wire o_first_timer_out, o_second_timer_out, o_first_on_end, o_second_on_end, o_cyclic_wake;
  int n_fail = 0, n_checks = 0, hi_len;
  always #25 i_sys_clk = ~i_sys_clk;
  cstw_timers dut_u (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_restart(i_restart),
    .i_hs_clear_t1(i_hs_clear_t1), .i_hs_clear_t2(i_hs_clear_t2), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
    .o_first_timer_out(o_first_timer_out), .o_second_timer_out(o_second_timer_out),
    .o_first_on_end(o_first_on_end), .o_second_on_end(o_second_on_end),
    .o_cyclic_wake(o_cyclic_wake));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle; every signal assigned once so strobes never glitch
  task automatic bus(input logic w, r, input logic [6:0] a, input logic [15:0] d, e);
    i_wr_en <= w;
    i_rd_en <= r;
    i_addr <= a;
    i_wr_data <= d;
    if (r) exp_q.push_back(e);
    @(posedge i_sys_clk);
  endtask
  // ==========================================
  // Read monitor: data is settled by the falling edge after the read edge
  always @(posedge i_sys_clk) rd_pend <= i_rd_en;
  always @(negedge i_sys_clk) if (rd_pend) chk(o_rd_data, exp_q.pop_front());
  task automatic close_out();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well past the roughly 6k cycles the tests need
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
  initial begin
    rnd = $urandom(32'h7743);
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(posedge i_sys_clk);
    bus(0, 1, 7'h06, 0, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      rnd = $urandom;
      bus(1, 0, 7'h06, rnd, 0);
      bus(0, 1, 7'h06, 0, rnd & 16'hEFF7);
    end
    bus(1, 0, 7'h05, 16'hFFFF, 0);
    bus(0, 1, 7'h05, 0, 16'h0000);
    bus(0, 1, 7'h06, 0, rnd & 16'hEFF7);
    $display("test register access done");
    // Stopped codes: low, high, and the reserved high alias
    foreach (oc[i]) begin
      bus(1, 0, 7'h06, {oc[i], 6'h00, oc[i], 4'h0}, 0);
      bus(0, 0, 7'h06, 0, 0);
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk({o_second_timer_out, o_first_timer_out}, (oc[i] != 0) ? 16'h0003 : 16'h0000);
    end
    $display("test stopped codes done");
    i_restart <= 1'b1;
    bus(0, 0, 7'h06, 0, 0);
    i_restart <= 1'b0;
    bus(0, 1, 7'h06, 0, 16'h0000);
    bus(1, 0, 7'h06, 16'h2A15, 0);
    i_hs_clear_t1 <= 1'b1;
    bus(0, 0, 7'h06, 0, 0);
    i_hs_clear_t1 <= 1'b0;
    bus(0, 1, 7'h06, 0, 16'h2A00);
    bus(1, 0, 7'h06, 16'h0A05, 0);
    i_hs_clear_t2 <= 1'b1;
    bus(0, 0, 7'h06, 0, 0);
    i_hs_clear_t2 <= 1'b0;
    bus(0, 1, 7'h06, 0, 16'h0A05);
    $display("test restart and switch clear done");
    // 0.3 ms on-time is 6000 cycles; the first may be one 2000-cycle tick short
    bus(1, 0, 7'h06, 16'h0020, 0);
    bus(0, 0, 7'h06, 0, 0);
    // Sample 1 ns after each edge so the registered outputs have settled
    for (hi_len = 0; o_first_timer_out !== 1'b1 && hi_len < 4100; hi_len++) begin
      @(posedge i_sys_clk);
      #1;
    end
    for (hi_len = 0; o_first_timer_out === 1'b1 && hi_len < 7000; hi_len++) begin
      @(posedge i_sys_clk);
      #1;
    end
    chk(hi_len >= 3999 && hi_len <= 6001, 16'h0001);
    // The end strobe rises on the same edge that drops the output
    chk({15'h0000, o_first_on_end}, 16'h0001);
    $display("test on-time done");
    repeat (3) @(posedge i_sys_clk);
    close_out();
  end
endmodule
`default_nettype wire
